// [hdl/shifter_flag_datapath.sv]
// shifter datapath: logical shifts, arithmetic-shift flag updates, flag register port
//
// Notes on behaviour
// (RL1) arithmetic shift sets zero flag from result
// (RL2) arithmetic shift sets negative flag from result
// (RL3) data destination: overflow flag follows overflow
// (RL4) data sticky overflow sets with overflow, else holds
// (RL5) first accumulator overflow flag set when result zero
// (RL6) first accumulator sticky follows its overflow set
// (RL7) second accumulator overflow on zero, sticky follows
// (RL8) other flags untouched by arithmetic shift
// (RL9) short shifts never paired; long pair selectively
// (RL10) logical shift drops bits, fills zeros
// (RL11) pointer shift by one or two only
// (RL12) pointer source kept unless it is destination
// (RL13) compound form: full magnitude, above 31 zero
// (RL14) signed form: low six bits, sign extended
// (RL15) positive distance left, negative right
// (RL16) word and accumulator distances -32 to +31
// (RL17) widths: half 16, word 32, accumulator 40
// (RL18) distance at or over width gives zero
// (RL19) zero distance passes operand unchanged
// (RL20) data source kept unless it is destination
// (RL21) long forms: separate registers, may pair
// (RL22) constants: half 0..15, word/accumulator 0..31
// (RL23) pointer shifts change no flag
// (RL24) logical shift: zero, negative, clear overflow
// (RL25) result and flags written back together
`timescale 1ns/1ps
`default_nettype none
`include "shifter_flag_datapath_regs.svh"

module shifter_flag_datapath
	import shifter_flag_datapath_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// issue from decoder
	input wire logic ISSUE,
	input wire logic [2:0] OP,
	input wire logic [1:0] SIZE,
	input wire logic SHIFT_LEFT,
	input wire logic LONG_ENC,
	input wire logic PAIRED,
	input wire logic [31:0] MAGNITUDE,
	input wire logic [39:0] OPERAND,
	input wire logic [2:0] SRC_IDX,
	input wire logic [2:0] DST_IDX,
	input wire logic [39:0] ARITH_RESULT,
	input wire logic ARITH_OFLOW,
	// write-back
	output logic WB_VALID,
	output logic WB_PTR,
	output logic [1:0] WB_SIZE,
	output logic [2:0] WB_DEST,
	output logic [39:0] WB_RESULT,
	output logic ILLEGAL_ISSUE,
	// status flags
	output logic RESULT_ZERO_FLAG,
	output logic RESULT_NEG_FLAG,
	output logic DATA_OFLOW,
	output logic DATA_OFLOW_STICKY,
	output logic ACCUM_FIRST_OFLOW,
	output logic ACCUM_FIRST_OFLOW_STICKY,
	output logic ACCUM_SECOND_OFLOW,
	output logic ACCUM_SECOND_OFLOW_STICKY,
	// register port
	input wire logic [`SFD_ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);

	// ************************************************************
	// shift helper
	// ************************************************************

	// amt is 0..64; the width mask keeps bits above the operand at zero
	function automatic logic [39:0] lshift(input logic [39:0] v, input logic [6:0] w,
		input logic left, input logic [6:0] amt);
		logic [39:0] mask;
		logic [39:0] res;
		mask = 40'hFF_FFFF_FFFF >> (7'h28 - w);
		// (RL18) oversize distance clears
		if (amt >= w) begin
			res = 40'h00_0000_0000;
		end else if (left) begin
			// (RL10) zero fill left
			res = (v << amt) & mask;
		end else begin
			// (RL10) zero fill right
			res = (v & mask) >> amt;
		end
		return res;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************

	state_s state_ff;
	state_s nxt_state;

	logic [6:0] width;
	logic [6:0] amt;
	logic left;
	logic [39:0] res;
	logic [39:0] masked;
	logic [5:0] sm;
	logic neg;
	logic zero;
	logic refuse;
	logic [7:0] wflags;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.valid = 1'b0;
		nxt_state.illegal = 1'b0;
		nxt_state.rdata = 32'h0000_0000;
		// (RL17) operand width per destination
		case (size_e'(SIZE))
			SZ_HALF: width = `SFD_W_HALF;
			SZ_WORD: width = `SFD_W_WORD;
			default: width = `SFD_W_ACC;
		endcase
		left = SHIFT_LEFT;
		amt = 7'h00;
		sm = MAGNITUDE[5:0];
		case (op_e'(OP))
			OP_PTR: begin
				// (RL11) pointer distance one or two
				width = `SFD_W_WORD;
				amt = MAGNITUDE[0] ? 7'h02 : 7'h01;
			end
			OP_LSH_CONST: begin
				// (RL22) unsigned constant field
				if (size_e'(SIZE) == SZ_HALF) begin
					amt = {3'h0, MAGNITUDE[3:0]};
				end else begin
					amt = {2'h0, MAGNITUDE[4:0]};
				end
			end
			OP_LSH_COMPOUND: begin
				// (RL13) whole 32-bit magnitude, word data
				width = `SFD_W_WORD;
				if (MAGNITUDE > `SFD_COMPOUND_MAX) begin
					amt = `SFD_AMT_ZERO;
				end else begin
					amt = {2'h0, MAGNITUDE[4:0]};
				end
			end
			OP_LSH_SIGNED: begin
				// (RL14) low six bits sign extended
				// (RL15) sign picks direction
				// (RL16) -32 maps to a distance of 32
				left = ~sm[5];
				amt = sm[5] ? {1'b0, 6'h00 - sm} : {1'b0, sm};
			end
			default: begin
				amt = 7'h00;
			end
		endcase
		// (RL19) zero distance leaves operand as is
		res = lshift(OPERAND, width, left, amt);
		if (op_e'(OP) == OP_ASH_FLAGS) begin
			res = ARITH_RESULT;
		end
		masked = res & (40'hFF_FFFF_FFFF >> (7'h28 - width));
		zero = (masked == 40'h00_0000_0000);
		case (width)
			`SFD_W_HALF: neg = masked[15];
			`SFD_W_WORD: neg = masked[31];
			default: neg = masked[39];
		endcase
		// (RL9) short encodings may not be paired
		// (RL21) long encodings may pair
		refuse = PAIRED & ~LONG_ENC;

		// software write of the flag register
		wflags = state_ff.flags;
		if (REG_WR && REG_ADDR == `SFD_OFF_FLAGS) begin
			wflags = REG_WDATA[7:0];
		end
		nxt_state.flags = wflags;

		if (ISSUE && refuse) begin
			nxt_state.illegal = 1'b1;
		end else if (ISSUE && op_e'(OP) != OP_NONE) begin
			// (RL25) result and flags land in one edge
			nxt_state.valid = 1'b1;
			nxt_state.result = masked;
			// (RL12) only the destination is written
			// (RL20) source untouched unless same index
			nxt_state.dest = DST_IDX;
			nxt_state.ptr = (op_e'(OP) == OP_PTR);
			nxt_state.size = (op_e'(OP) == OP_PTR || op_e'(OP) == OP_LSH_COMPOUND) ? SZ_WORD : size_e'(SIZE);
			if (op_e'(OP) == OP_PTR) begin
				// (RL23) pointer shift keeps all flags
				nxt_state.flags = wflags;
			end else begin
				// (RL1) zero from result
				nxt_state.flags[`SFD_BIT_ZERO] = zero;
				// (RL2) negative from result
				nxt_state.flags[`SFD_BIT_NEG] = neg;
				// (RL8) only destination overflow bits touched
				if (op_e'(OP) == OP_ASH_FLAGS) begin
					case (size_e'(SIZE))
						SZ_ACC0: begin
							// (RL5) set on zero result
							nxt_state.flags[`SFD_BIT_A0V] = zero;
							// (RL6) sticky follows, set wins
							nxt_state.flags[`SFD_BIT_A0VS] = wflags[`SFD_BIT_A0VS] | zero;
						end
						SZ_ACC1: begin
							// (RL7) set on zero, sticky follows
							nxt_state.flags[`SFD_BIT_A1V] = zero;
							nxt_state.flags[`SFD_BIT_A1VS] = wflags[`SFD_BIT_A1VS] | zero;
						end
						default: begin
							// (RL3) overflow from arithmetic unit
							nxt_state.flags[`SFD_BIT_DOV] = ARITH_OFLOW;
							// (RL4) sticky set wins over write
							nxt_state.flags[`SFD_BIT_DOVS] = wflags[`SFD_BIT_DOVS] | ARITH_OFLOW;
						end
					endcase
				end else begin
					// (RL24) logical shift clears overflow
					case (nxt_state.size)
						SZ_ACC0: nxt_state.flags[`SFD_BIT_A0V] = 1'b0;
						SZ_ACC1: nxt_state.flags[`SFD_BIT_A1V] = 1'b0;
						default: nxt_state.flags[`SFD_BIT_DOV] = 1'b0;
					endcase
				end
			end
		end

		// read data stands the cycle after the strobe only
		if (REG_RD) begin
			case (REG_ADDR)
				`SFD_OFF_FLAGS: nxt_state.rdata = {24'h00_0000, state_ff.flags};
				`SFD_OFF_RES_LO: nxt_state.rdata = state_ff.result[31:0];
				`SFD_OFF_RES_HI: nxt_state.rdata = {24'h00_0000, state_ff.result[39:32]};
				default: nxt_state.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			state_ff <= '{result: 40'h00_0000_0000, dest: 3'h0, valid: 1'b0, ptr: 1'b0,
				size: SZ_HALF, illegal: 1'b0, flags: `SFD_FLAGS_RST, rdata: 32'h0000_0000};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************

	assign WB_VALID = state_ff.valid;
	assign WB_PTR = state_ff.ptr;
	assign WB_SIZE = state_ff.size;
	assign WB_DEST = state_ff.dest;
	assign WB_RESULT = state_ff.result;
	assign ILLEGAL_ISSUE = state_ff.illegal;
	assign RESULT_ZERO_FLAG = state_ff.flags[`SFD_BIT_ZERO];
	assign RESULT_NEG_FLAG = state_ff.flags[`SFD_BIT_NEG];
	assign DATA_OFLOW = state_ff.flags[`SFD_BIT_DOV];
	assign DATA_OFLOW_STICKY = state_ff.flags[`SFD_BIT_DOVS];
	assign ACCUM_FIRST_OFLOW = state_ff.flags[`SFD_BIT_A0V];
	assign ACCUM_FIRST_OFLOW_STICKY = state_ff.flags[`SFD_BIT_A0VS];
	assign ACCUM_SECOND_OFLOW = state_ff.flags[`SFD_BIT_A1V];
	assign ACCUM_SECOND_OFLOW_STICKY = state_ff.flags[`SFD_BIT_A1VS];
	assign REG_RDATA = state_ff.rdata;

endmodule

`default_nettype wire

// [hdl/shifter_flag_datapath_pkg.sv]
// types shared by the shifter flag datapath
package shifter_flag_datapath_pkg;

	// operation issued by the decoder
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_PTR = 3'h1,
		OP_LSH_CONST = 3'h2,
		OP_LSH_COMPOUND = 3'h3,
		OP_LSH_SIGNED = 3'h4,
		OP_ASH_FLAGS = 3'h5
	} op_e;

	// destination type
	typedef enum logic [1:0] {
		SZ_HALF = 2'h0,
		SZ_WORD = 2'h1,
		SZ_ACC0 = 2'h2,
		SZ_ACC1 = 2'h3
	} size_e;

	typedef struct packed {
		logic [39:0] result;
		logic [2:0] dest;
		logic valid;
		logic ptr;
		size_e size;
		logic illegal;
		logic [7:0] flags;
		logic [31:0] rdata;
	} state_s;

endpackage

// [hdl/shifter_flag_datapath_regs.svh]
// register offsets, field positions, reset values and fixed widths of the shifter
`ifndef SHIFTER_FLAG_DATAPATH_REGS_SVH
`define SHIFTER_FLAG_DATAPATH_REGS_SVH

// register offsets (byte addresses)
`define SFD_ADDR_W 4
`define SFD_OFF_FLAGS 4'h0
`define SFD_OFF_RES_LO 4'h4
`define SFD_OFF_RES_HI 4'h8

// flag register bit positions
`define SFD_BIT_ZERO 0
`define SFD_BIT_NEG 1
`define SFD_BIT_DOV 2
`define SFD_BIT_DOVS 3
`define SFD_BIT_A0V 4
`define SFD_BIT_A0VS 5
`define SFD_BIT_A1V 6
`define SFD_BIT_A1VS 7
`define SFD_FLAGS_RST 8'h00

// operand widths and shift limits
`define SFD_W_HALF 7'h10
`define SFD_W_WORD 7'h20
`define SFD_W_ACC 7'h28
`define SFD_AMT_ZERO 7'h40
`define SFD_COMPOUND_MAX 32'h0000001F

`endif

// [tb/shifter_flag_datapath_assertions.sv]
// port checker for the shifter flag datapath
`timescale 1ns/1ps
`default_nettype none
module shifter_flag_datapath_chk (
	// clock and issue
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic ISSUE,
	input wire logic [2:0] OP,
	input wire logic [1:0] SIZE,
	input wire logic LONG_ENC,
	input wire logic PAIRED,
	input wire logic REG_WR,
	input wire logic [39:0] OPERAND,
	input wire logic [31:0] MAGNITUDE,
	input wire logic ARITH_OFLOW,
	// results and flags
	input wire logic WB_VALID,
	input wire logic WB_PTR,
	input wire logic [39:0] WB_RESULT,
	input wire logic ILLEGAL_ISSUE,
	input wire logic RESULT_ZERO_FLAG,
	input wire logic RESULT_NEG_FLAG,
	input wire logic DATA_OFLOW,
	input wire logic DATA_OFLOW_STICKY,
	input wire logic ACCUM_FIRST_OFLOW,
	input wire logic ACCUM_FIRST_OFLOW_STICKY,
	input wire logic ACCUM_SECOND_OFLOW,
	input wire logic ACCUM_SECOND_OFLOW_STICKY
);
	// a refused short op must not count as issued
	wire go = ISSUE && OP != 3'h0 && (LONG_ENC || !PAIRED);
	wire [7:0] fl = {ACCUM_SECOND_OFLOW_STICKY, ACCUM_SECOND_OFLOW, ACCUM_FIRST_OFLOW_STICKY,
		ACCUM_FIRST_OFLOW, DATA_OFLOW_STICKY, DATA_OFLOW, RESULT_NEG_FLAG, RESULT_ZERO_FLAG};
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	wb_follows_a: assert property (go |=> WB_VALID && !ILLEGAL_ISSUE) else $error("no write-back");
	short_pair_a: assert property (ISSUE && OP != 3'h0 && PAIRED && !LONG_ENC |=> ILLEGAL_ISSUE && !WB_VALID)
		else $error("short paired op accepted");
	ptr_flags_a: assert property (go && OP == 3'h1 && !REG_WR |=> $stable(fl)) else $error("pointer changed flags");
	zero_flag_a: assert property (WB_VALID && !WB_PTR |-> RESULT_ZERO_FLAG == (WB_RESULT == 40'h0))
		else $error("zero flag wrong");
	acc_zero_a: assert property (go && OP == 3'h5 && SIZE == 2'h2 |=> ACCUM_FIRST_OFLOW == RESULT_ZERO_FLAG
		&& (!ACCUM_FIRST_OFLOW || ACCUM_FIRST_OFLOW_STICKY)) else $error("accum overflow wrong");
	data_sticky_a: assert property (go && OP == 3'h5 && !SIZE[1] && ARITH_OFLOW |=> DATA_OFLOW && DATA_OFLOW_STICKY)
		else $error("data sticky not set");
	sticky_hold_a: assert property ($fell(DATA_OFLOW_STICKY) || $fell(ACCUM_FIRST_OFLOW_STICKY)
		|| $fell(ACCUM_SECOND_OFLOW_STICKY) |-> $past(REG_WR)) else $error("sticky cleared");
	pass_zero_a: assert property (go && OP == 3'h2 && SIZE == 2'h2 && MAGNITUDE[4:0] == 5'h00
		|=> WB_RESULT == $past(OPERAND)) else $error("zero distance changed operand");
	cover property (go && OP == 3'h5);
	cover property (ILLEGAL_ISSUE);
	cover property (go && OP == 3'h1);
endmodule
bind shifter_flag_datapath shifter_flag_datapath_chk shifter_flag_datapath_chk_i (.*);
`default_nettype wire

// [tb/shifter_flag_datapath_test.sv]
// self-checking bench for the shifter flag datapath
`timescale 1ns/1ps
`default_nettype none
`include "shifter_flag_datapath_regs.svh"
module shifter_flag_datapath_test;
	logic SYS_CLK = '0, NRST = '0, ISSUE = '0, SHIFT_LEFT = '0, LONG_ENC = '0, PAIRED = '0;
	logic ARITH_OFLOW = '0, REG_WR = '0, REG_RD = '0;
	logic [2:0] OP = '0, SRC_IDX = '0, DST_IDX = '0;
	logic [1:0] SIZE = '0;
	logic [31:0] MAGNITUDE = '0, REG_WDATA = '0, REG_RDATA;
	logic [39:0] OPERAND = '0, ARITH_RESULT = '0, WB_RESULT;
	logic [`SFD_ADDR_W-1:0] REG_ADDR = '0;
	logic WB_VALID, WB_PTR, ILLEGAL_ISSUE, RESULT_ZERO_FLAG, RESULT_NEG_FLAG, DATA_OFLOW;
	logic DATA_OFLOW_STICKY, ACCUM_FIRST_OFLOW, ACCUM_FIRST_OFLOW_STICKY;
	logic ACCUM_SECOND_OFLOW, ACCUM_SECOND_OFLOW_STICKY;
	logic [1:0] WB_SIZE;
	logic [2:0] WB_DEST;
	int failures = 0, checks_done = 0;
	wire [7:0] fl = {ACCUM_SECOND_OFLOW_STICKY, ACCUM_SECOND_OFLOW, ACCUM_FIRST_OFLOW_STICKY,
		ACCUM_FIRST_OFLOW, DATA_OFLOW_STICKY, DATA_OFLOW, RESULT_NEG_FLAG, RESULT_ZERO_FLAG};
	shifter_flag_datapath shifter_flag_datapath_i (.*);
	always #2 SYS_CLK = ~SYS_CLK;
	// ******************
	// tasks
	// ******************
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// pointer ops are short encodings, the rest long
	task automatic t(input logic [2:0] o, input logic [1:0] s, input logic l, input logic p,
		input logic [31:0] m, input logic [39:0] x, input logic [39:0] r, input logic [7:0] f);
		@(posedge SYS_CLK);
		ISSUE <= 1'h1;
		OP <= o;
		SIZE <= s;
		SHIFT_LEFT <= l;
		ARITH_OFLOW <= l;
		LONG_ENC <= o != 3'h1;
		PAIRED <= p;
		MAGNITUDE <= m;
		OPERAND <= x;
		ARITH_RESULT <= x;
		DST_IDX <= o;
		@(posedge SYS_CLK);
		ISSUE <= 1'h0;
		#1;
		chk("dest", {37'h0, o}, {37'h0, WB_DEST});
		chk("ptr", {39'h0, o == 3'h1}, {39'h0, WB_PTR});
		chk("size", {38'h0, (o == 3'h1 || o == 3'h3) ? 2'h1 : s}, {38'h0, WB_SIZE});
		chk("illegal", {39'h0, p && o == 3'h1}, {39'h0, ILLEGAL_ISSUE});
		chk("valid", {39'h0, !(p && o == 3'h1)}, {39'h0, WB_VALID});
		chk("result", r, WB_RESULT);
		chk("flags", {32'h0, f}, {32'h0, fl});
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge SYS_CLK);
		REG_RD <= 1'h1;
		REG_ADDR <= a;
		@(posedge SYS_CLK);
		REG_RD <= 1'h0;
		#1;
		chk("rdata", {8'h0, e}, {8'h0, REG_RDATA});
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		REG_WR <= 1'h1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge SYS_CLK);
		REG_WR <= 1'h0;
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ******************
	// run
	// ******************
	initial begin
		#20000;
		failures++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge SYS_CLK);
		NRST <= 1'h1;
		t(3'h2, 2'h0, 1'h1, 1'h0, 32'h4, 40'hFFFF, 40'hFFF0, 8'h02);
		t(3'h2, 2'h1, 1'h0, 1'h0, 32'h1F, 40'h80000000, 40'h1, 8'h00);
		t(3'h2, 2'h2, 1'h1, 1'h1, 32'h0, 40'h8000000001, 40'h8000000001, 8'h02);
		rd(`SFD_OFF_RES_HI, 32'h80);
		rd(`SFD_OFF_RES_LO, 32'h1);
		t(3'h3, 2'h1, 1'h1, 1'h0, 32'h20, 40'hFFFFFFFF, 40'h0, 8'h01);
		t(3'h3, 2'h1, 1'h1, 1'h0, 32'h1F, 40'h1, 40'h80000000, 8'h02);
		t(3'h4, 2'h1, 1'h1, 1'h0, 32'hFF3F, 40'h4, 40'h2, 8'h00);
		t(3'h4, 2'h1, 1'h0, 1'h0, 32'h20, 40'hFFFFFFFF, 40'h0, 8'h01);
		t(3'h4, 2'h3, 1'h0, 1'h0, 32'h1F, 40'h1, 40'h80000000, 8'h00);
		t(3'h4, 2'h0, 1'h0, 1'h0, 32'h10, 40'h1, 40'h0, 8'h01);
		t(3'h5, 2'h1, 1'h1, 1'h0, 32'h0, 40'h80000000, 40'h80000000, 8'h0E);
		t(3'h2, 2'h1, 1'h1, 1'h0, 32'h1, 40'h1, 40'h2, 8'h08);
		t(3'h5, 2'h0, 1'h0, 1'h0, 32'h0, 40'h0, 40'h0, 8'h09);
		t(3'h5, 2'h2, 1'h0, 1'h0, 32'h0, 40'h0, 40'h0, 8'h39);
		t(3'h2, 2'h2, 1'h1, 1'h0, 32'h1, 40'h1, 40'h2, 8'h28);
		t(3'h5, 2'h3, 1'h1, 1'h0, 32'h0, 40'h5, 40'h5, 8'h28);
		t(3'h5, 2'h3, 1'h0, 1'h0, 32'h0, 40'h0, 40'h0, 8'hE9);
		t(3'h1, 2'h1, 1'h1, 1'h0, 32'h1, 40'h1, 40'h4, 8'hE9);
		t(3'h1, 2'h1, 1'h0, 1'h0, 32'h0, 40'h6, 40'h3, 8'hE9);
		t(3'h1, 2'h1, 1'h1, 1'h1, 32'h1, 40'h1, 40'h3, 8'hE9);
		rd(`SFD_OFF_FLAGS, 32'hE9);
		rd(4'hC, 32'h0);
		wr(`SFD_OFF_RES_LO, 32'hFFFFFFFF);
		rd(`SFD_OFF_RES_LO, 32'h3);
		wr(`SFD_OFF_FLAGS, 32'h0);
		rd(`SFD_OFF_FLAGS, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
